// ---- core/sfadc_pkg.sv ----
// shared widths, reset values and encodings of the two-step converter core
// assumes one system clock that oversamples the converter clock pin

package sfadc_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int ANA_W  = 12;  // digitised analog input and references
	localparam int CODE_W = 8;   // output word
	localparam int NIB_W  = 4;   // one nibble of the word
	localparam int STAGES = 2;   // lower-nibble stages served in turn
	localparam int FRAC_W = ANA_W + CODE_W;  // scaled difference

	// ****************************************************************
	// codes and reset values
	// ****************************************************************
	localparam logic [CODE_W-1:0] CODE_MIN   = 8'h00;
	localparam logic [CODE_W-1:0] CODE_MAX   = 8'hff;
	localparam logic [CODE_W-1:0] CODE_RST   = 8'h00;
	localparam logic [NIB_W-1:0]  NIB_RST    = 4'h0;
	localparam logic [ANA_W-1:0]  ANA_RST    = 12'h000;
	localparam logic              OE_N_RST   = 1'b1;   // bus released
	localparam logic              CLK_RST    = 1'b0;

	// pipeline depth in converter rising edges from sample to output
	localparam int LAT_RISES = 3;

	// ****************************************************************
	// phase encoding of the converter clock
	// ****************************************************************
	typedef enum logic [1:0] {
		SFADC_PH_GAP_LO = 2'b00,  // dead time before sampling
		SFADC_PH_SAMPLE = 2'b01,  // input connected to the cap
		SFADC_PH_GAP_HI = 2'b10,  // dead time before compare
		SFADC_PH_COMP   = 2'b11   // reference applied, compare
	} sfadc_phase_t;

endpackage : sfadc_pkg

// ---- core/sfadc_quant.sv ----
// linear straight-binary quantiser with saturation
// assumes synchronised inputs; purely combinational

`timescale 1ns/10ps
`default_nettype none

module sfadc_quant (
	input  wire logic [sfadc_pkg::ANA_W-1:0]  value_i,
	input  wire logic [sfadc_pkg::ANA_W-1:0]  top_reference_i,
	input  wire logic [sfadc_pkg::ANA_W-1:0]  bottom_reference_i,
	output logic      [sfadc_pkg::CODE_W-1:0] code_o
);

	logic [sfadc_pkg::ANA_W-1:0]  span;
	logic [sfadc_pkg::ANA_W-1:0]  offs;
	logic [sfadc_pkg::FRAC_W-1:0] scaled;
	logic [sfadc_pkg::FRAC_W-1:0] ratio;

	// ****************************************************************
	// scale (v - bottom) over the span onto 256 steps
	// ****************************************************************
	// the divider is large but runs once per converter clock anyway
	always_comb begin
		span   = top_reference_i - bottom_reference_i;
		offs   = value_i - bottom_reference_i;
		scaled = {offs, {sfadc_pkg::CODE_W{1'b0}}};
		ratio  = '0;
		if (value_i <= bottom_reference_i ||
				top_reference_i <= bottom_reference_i) begin
			code_o = sfadc_pkg::CODE_MIN;
		end else if (value_i >= top_reference_i) begin
			code_o = sfadc_pkg::CODE_MAX;
		end else begin
			ratio = scaled / {{sfadc_pkg::CODE_W{1'b0}}, span};
			if (ratio > {{sfadc_pkg::ANA_W{1'b0}}, sfadc_pkg::CODE_MAX})
				code_o = sfadc_pkg::CODE_MAX;
			else
				code_o = ratio[sfadc_pkg::CODE_W-1:0];
		end
	end

endmodule : sfadc_quant

`default_nettype wire

// ---- core/sfadc_core.sv ----
// timing and sequencing of an 8-bit two-step sampling converter
// assumes clock_i far faster than conv_clk_i; all pins but nrst_i come in async

`timescale 1ns/10ps
`default_nettype none

module sfadc_core (
	input  wire logic                          clock_i,
	input  wire logic                          nrst_i,
	input  wire logic                          conv_clk_i,
	input  wire logic                          out_en_n_i,
	input  wire logic [sfadc_pkg::ANA_W-1:0]   sample_value_i,
	input  wire logic [sfadc_pkg::ANA_W-1:0]   top_reference_i,
	input  wire logic [sfadc_pkg::ANA_W-1:0]   bottom_reference_i,
	output logic      [sfadc_pkg::CODE_W-1:0]  sample_code_out_o,
	output logic      [sfadc_pkg::CODE_W-1:0]  sample_code_oe_o,
	output logic                               code_strobe_o,
	output logic                               phase_sample_o,
	output logic                               phase_compare_o
);

	localparam int AW = sfadc_pkg::ANA_W;
	localparam int CW = sfadc_pkg::CODE_W;
	localparam int NW = sfadc_pkg::NIB_W;
	localparam int NS = sfadc_pkg::STAGES;

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	logic          clk_s1_q, clk_s2_q, clk_s3_q;
	logic          oen_s1_q, oen_s2_q;
	logic [AW-1:0] val_s1_q, val_s2_q;
	logic [AW-1:0] top_s1_q, top_s2_q;
	logic [AW-1:0] bot_s1_q, bot_s2_q;
	logic          clk_s1_d, clk_s2_d, clk_s3_d;
	logic          oen_s1_d, oen_s2_d;
	logic [AW-1:0] val_s1_d, val_s2_d;
	logic [AW-1:0] top_s1_d, top_s2_d;
	logic [AW-1:0] bot_s1_d, bot_s2_d;

	// analog words are held steady by the source around the sample edge,
	// so a plain two-flop chain is enough here
	always_comb begin
		clk_s1_d = conv_clk_i;
		clk_s2_d = clk_s1_q;
		clk_s3_d = clk_s2_q;      // history for edge detection
		oen_s1_d = out_en_n_i;
		oen_s2_d = oen_s1_q;
		val_s1_d = sample_value_i;
		val_s2_d = val_s1_q;
		top_s1_d = top_reference_i;
		top_s2_d = top_s1_q;
		bot_s1_d = bottom_reference_i;
		bot_s2_d = bot_s1_q;
		if (!nrst_i) begin
			clk_s1_d = sfadc_pkg::CLK_RST;
			clk_s2_d = sfadc_pkg::CLK_RST;
			clk_s3_d = sfadc_pkg::CLK_RST;
			oen_s1_d = sfadc_pkg::OE_N_RST;
			oen_s2_d = sfadc_pkg::OE_N_RST;
			val_s1_d = sfadc_pkg::ANA_RST;
			val_s2_d = sfadc_pkg::ANA_RST;
			top_s1_d = sfadc_pkg::ANA_RST;
			top_s2_d = sfadc_pkg::ANA_RST;
			bot_s1_d = sfadc_pkg::ANA_RST;
			bot_s2_d = sfadc_pkg::ANA_RST;
		end
	end

	// registers of the synchronisers
	always_ff @(posedge clock_i) begin
		clk_s1_q <= clk_s1_d;
		clk_s2_q <= clk_s2_d;
		clk_s3_q <= clk_s3_d;
		oen_s1_q <= oen_s1_d;
		oen_s2_q <= oen_s2_d;
		val_s1_q <= val_s1_d;
		val_s2_q <= val_s2_d;
		top_s1_q <= top_s1_d;
		top_s2_q <= top_s2_d;
		bot_s1_q <= bot_s1_d;
		bot_s2_q <= bot_s2_d;
	end

	// edges of the converter clock, seen two system cycles late
	logic conv_fall;
	logic conv_rise;
	assign conv_fall = clk_s3_q & ~clk_s2_q;
	assign conv_rise = ~clk_s3_q & clk_s2_q;

	// ****************************************************************
	// phase generator
	// ****************************************************************
	sfadc_pkg::sfadc_phase_t ph_q, ph_d;
	logic                    ph_smp_q, ph_smp_d;
	logic                    ph_cmp_q, ph_cmp_d;

	// each level change passes a gap state first, so the two phase
	// outputs are never high in the same cycle
	always_comb begin
		ph_d = ph_q;
		case (ph_q)
			sfadc_pkg::SFADC_PH_GAP_LO: ph_d = clk_s2_q ?
				sfadc_pkg::SFADC_PH_GAP_HI : sfadc_pkg::SFADC_PH_SAMPLE;
			sfadc_pkg::SFADC_PH_SAMPLE: if (clk_s2_q) begin
				ph_d = sfadc_pkg::SFADC_PH_GAP_HI;
			end
			sfadc_pkg::SFADC_PH_GAP_HI: ph_d = clk_s2_q ?
				sfadc_pkg::SFADC_PH_COMP : sfadc_pkg::SFADC_PH_GAP_LO;
			sfadc_pkg::SFADC_PH_COMP: if (!clk_s2_q) begin
				ph_d = sfadc_pkg::SFADC_PH_GAP_LO;
			end
			default: ph_d = sfadc_pkg::SFADC_PH_GAP_LO;
		endcase
		if (!nrst_i)
			ph_d = sfadc_pkg::SFADC_PH_GAP_LO;
		ph_smp_d = (ph_d == sfadc_pkg::SFADC_PH_SAMPLE);
		ph_cmp_d = (ph_d == sfadc_pkg::SFADC_PH_COMP);
	end

	// phase registers
	always_ff @(posedge clock_i) begin
		ph_q     <= ph_d;
		ph_smp_q <= ph_smp_d;
		ph_cmp_q <= ph_cmp_d;
	end

	// ****************************************************************
	// sample slots, one per lower stage
	// ****************************************************************
	logic [AW-1:0] hold_q   [NS];
	logic [AW-1:0] hold_d   [NS];
	logic [AW-1:0] tref_q   [NS];
	logic [AW-1:0] tref_d   [NS];
	logic [AW-1:0] bref_q   [NS];
	logic [AW-1:0] bref_d   [NS];
	logic [CW-1:0] qcode    [NS];
	logic          sel_q, sel_d;     // slot of the newest sample
	logic [NS-1:0] live_q, live_d;   // slot holds a real sample

	// one quantiser per slot, the stage does the compare itself
	for (genvar g = 0; g < NS; g++) begin : g_stage
		sfadc_quant u_quant (
			.value_i            (hold_q[g]),
			.top_reference_i    (tref_q[g]),
			.bottom_reference_i (bref_q[g]),
			.code_o             (qcode[g])
		);
	end

	// capture on the falling edge into the next slot in turn
	always_comb begin
		sel_d  = sel_q;
		live_d = live_q;
		for (int i = 0; i < NS; i++) begin
			hold_d[i] = hold_q[i];
			tref_d[i] = tref_q[i];
			bref_d[i] = bref_q[i];
		end
		if (conv_fall) begin
			sel_d = ~sel_q;
			hold_d[int'(~sel_q)] = val_s2_q;
			tref_d[int'(~sel_q)] = top_s2_q;
			bref_d[int'(~sel_q)] = bot_s2_q;
			live_d[int'(~sel_q)] = 1'b1;
		end
		if (!nrst_i) begin
			sel_d  = 1'b1;   // first sample lands in the first stage
			live_d = '0;
			for (int i = 0; i < NS; i++) begin
				hold_d[i] = sfadc_pkg::ANA_RST;
				tref_d[i] = sfadc_pkg::ANA_RST;
				bref_d[i] = sfadc_pkg::ANA_RST;
			end
		end
	end

	// slot registers
	always_ff @(posedge clock_i) begin
		sel_q  <= sel_d;
		live_q <= live_d;
		for (int i = 0; i < NS; i++) begin
			hold_q[i] <= hold_d[i];
			tref_q[i] <= tref_d[i];
			bref_q[i] <= bref_d[i];
		end
	end

	// ****************************************************************
	// nibble pipeline on rising edges
	// ****************************************************************
	logic [NW-1:0] upper_nibble_result_q [NS];
	logic [NW-1:0] upper_nibble_result_d [NS];
	logic [CW-1:0] joined_q, joined_d;
	logic          joined_ok_q, joined_ok_d;
	logic [NS-1:0] up_ok_q, up_ok_d;
	logic [NW-1:0] lower_nibble_result;
	logic          old;

	// at a rise the newest slot resolves its upper nibble while the
	// older slot resolves its lower one and joins both halves
	always_comb begin
		old = ~sel_q;
		lower_nibble_result = qcode[int'(old)][NW-1:0];
		up_ok_d  = up_ok_q;
		joined_d = joined_q;
		joined_ok_d = joined_ok_q;
		for (int i = 0; i < NS; i++)
			upper_nibble_result_d[i] = upper_nibble_result_q[i];
		if (conv_rise) begin
			upper_nibble_result_d[int'(sel_q)] =
				qcode[int'(sel_q)][CW-1:NW];
			up_ok_d[int'(sel_q)] = live_q[int'(sel_q)];
			joined_d = {upper_nibble_result_q[int'(old)],
				lower_nibble_result};
			joined_ok_d = up_ok_q[int'(old)];
			up_ok_d[int'(old)] = 1'b0;  // each sample leaves once
		end
		if (!nrst_i) begin
			up_ok_d     = '0;
			joined_d    = sfadc_pkg::CODE_RST;
			joined_ok_d = 1'b0;
			for (int i = 0; i < NS; i++)
				upper_nibble_result_d[i] = sfadc_pkg::NIB_RST;
		end
	end

	// pipeline registers
	always_ff @(posedge clock_i) begin
		up_ok_q     <= up_ok_d;
		joined_q    <= joined_d;
		joined_ok_q <= joined_ok_d;
		for (int i = 0; i < NS; i++)
			upper_nibble_result_q[i] <= upper_nibble_result_d[i];
	end

	// ****************************************************************
	// output bus
	// ****************************************************************
	logic [CW-1:0] out_q, out_d;
	logic [CW-1:0] oe_q, oe_d;
	logic          stb_q, stb_d;

	// the word moves to the bus one rise after joining, the third
	// rise after its sample; the enable acts on every line at once
	always_comb begin
		out_d = out_q;
		stb_d = 1'b0;
		if (conv_rise && joined_ok_q) begin
			out_d = joined_q;
			stb_d = 1'b1;
		end
		oe_d = {CW{~oen_s2_q}};
		if (!nrst_i) begin
			out_d = sfadc_pkg::CODE_RST;
			stb_d = 1'b0;
			oe_d  = '0;
		end
	end

	// output registers
	always_ff @(posedge clock_i) begin
		out_q <= out_d;
		oe_q  <= oe_d;
		stb_q <= stb_d;
	end

	assign sample_code_out_o = out_q;
	assign sample_code_oe_o  = oe_q;
	assign code_strobe_o     = stb_q;
	assign phase_sample_o    = ph_smp_q;
	assign phase_compare_o   = ph_cmp_q;

endmodule : sfadc_core

`default_nettype wire

// ---- test/sfadc_chk.sv ----
// checker of output timing, phases and bus enable of the converter core
// assumes it is bound to the core and sees only the core's ports

`timescale 1ns/10ps
`default_nettype none

module sfadc_chk (
	input wire logic                         clock_i,
	input wire logic                         nrst_i,
	input wire logic                         conv_clk_i,
	input wire logic                         out_en_n_i,
	input wire logic [sfadc_pkg::ANA_W-1:0]  sample_value_i,
	input wire logic [sfadc_pkg::ANA_W-1:0]  top_reference_i,
	input wire logic [sfadc_pkg::ANA_W-1:0]  bottom_reference_i,
	input wire logic [sfadc_pkg::CODE_W-1:0] sample_code_out_o,
	input wire logic [sfadc_pkg::CODE_W-1:0] sample_code_oe_o,
	input wire logic                         code_strobe_o,
	input wire logic                         phase_sample_o,
	input wire logic                         phase_compare_o
);
	// ****************
	// helper logic
	// ****************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	logic       conv_q;
	logic [3:0] age_q;
	logic [3:0] age_d;
	// saturating age since the last converter rise; 15 means long ago
	always_comb begin
		age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
		if (conv_clk_i && !conv_q)
			age_d = 4'h0;
	end
	always_ff @(posedge clock_i) begin
		conv_q <= conv_clk_i;
		age_q  <= nrst_i ? age_d : 4'hf;
	end
	// ****************
	// properties
	// ****************
	property p_lat; code_strobe_o |-> age_q inside {[4'h2:4'h4]}; endproperty
	a_lat: assert property (p_lat) else $error("strobe off rise");
	property p_pulse; code_strobe_o |=> !code_strobe_o; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe long");
	property p_hold; !code_strobe_o |-> $stable(sample_code_out_o); endproperty
	a_hold: assert property (p_hold) else $error("code moved");
	property p_excl; !(phase_sample_o && phase_compare_o); endproperty
	a_excl: assert property (p_excl) else $error("phase overlap");
	property p_smp; $fell(conv_clk_i) |-> ##[2:6] phase_sample_o; endproperty
	a_smp: assert property (p_smp) else $error("no sample phase");
	property p_cmp; $rose(conv_clk_i) |-> ##[2:6] phase_compare_o; endproperty
	a_cmp: assert property (p_cmp) else $error("no compare phase");
	property p_gap; $rose(phase_sample_o) |-> !$past(phase_compare_o); endproperty
	a_gap: assert property (p_gap) else $error("no phase gap");
	property p_on; $fell(out_en_n_i) |-> ##[2:4] sample_code_oe_o == 8'hff;
	endproperty
	a_on: assert property (p_on) else $error("bus not driven");
	property p_off; out_en_n_i [*5] |-> sample_code_oe_o == 8'h00; endproperty
	a_off: assert property (p_off) else $error("bus not released");
	c_full: cover property (code_strobe_o && sample_code_out_o == 8'hff);
	c_rel: cover property (code_strobe_o && sample_code_oe_o == 8'h00);
	c_phase: cover property ($rose(phase_sample_o));
endmodule : sfadc_chk

bind sfadc_core sfadc_chk i_chk (
	.clock_i(clock_i), .nrst_i(nrst_i), .conv_clk_i(conv_clk_i),
	.out_en_n_i(out_en_n_i), .sample_value_i(sample_value_i),
	.top_reference_i(top_reference_i),
	.bottom_reference_i(bottom_reference_i),
	.sample_code_out_o(sample_code_out_o),
	.sample_code_oe_o(sample_code_oe_o), .code_strobe_o(code_strobe_o),
	.phase_sample_o(phase_sample_o), .phase_compare_o(phase_compare_o)
);

`default_nettype wire

// ---- test/sfadc_sink.sv ----
// capture logic downstream of the converter output bus
// assumes the bench resolves the bus pins; a released pin reads z

`timescale 1ns/10ps
`default_nettype none

module sfadc_sink (
	input  wire logic                         clock_i,
	input  wire logic                         strobe_i,
	input  wire logic [sfadc_pkg::CODE_W-1:0] bus_i,
	input  wire logic                         release_i,
	output logic                              out_en_n_o
);
	// ****************
	// capture
	// ****************
	logic [sfadc_pkg::CODE_W-1:0] words[$];
	// the enable is ours to drive; the core only follows it
	assign out_en_n_o = release_i;
	// take the word in the cycle it first shows, floating lines included
	always @(posedge clock_i)
		if (strobe_i === 1'b1)
			words.push_back(bus_i);
endmodule : sfadc_sink

`default_nettype wire

// ---- test/sfadc_tb.sv ----
// self-checking bench of the converter core with a capturing sink
// assumes the bound checker watches timing; here words and values

`timescale 1ns/10ps
`default_nettype none

module testbench;
	typedef logic [sfadc_pkg::ANA_W-1:0] sfadc_vq_t[$];
	typedef logic [sfadc_pkg::CODE_W-1:0] sfadc_eq_t[$];
	logic                          clock_i;
	logic                          nrst_i;
	logic                          conv_clk;
	logic                          rel;
	logic [sfadc_pkg::ANA_W-1:0]   value;
	logic [sfadc_pkg::ANA_W-1:0]   top_ref;
	logic [sfadc_pkg::ANA_W-1:0]   bot_ref;
	logic [sfadc_pkg::CODE_W-1:0]  code;
	logic [sfadc_pkg::CODE_W-1:0]  oe;
	logic                          strobe;
	wire                           en_n;
	wire  [sfadc_pkg::CODE_W-1:0]  bus_w;
	int                            miscompares;
	int                            checks_done;
	int                            cycles;
	// ****************
	// pins and parts
	// ****************
	for (genvar i = 0; i < sfadc_pkg::CODE_W; i++) begin : g_pin
		assign bus_w[i] = oe[i] ? code[i] : 1'bz;
	end
	sfadc_core i_dut (.clock_i(clock_i), .nrst_i(nrst_i),
		.conv_clk_i(conv_clk), .out_en_n_i(en_n), .sample_value_i(value),
		.top_reference_i(top_ref), .bottom_reference_i(bot_ref),
		.sample_code_out_o(code), .sample_code_oe_o(oe),
		.code_strobe_o(strobe), .phase_sample_o(), .phase_compare_o());
	sfadc_sink i_sink (.clock_i(clock_i), .strobe_i(strobe), .bus_i(bus_w),
		.release_i(rel), .out_en_n_o(en_n));
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	// a hang ends here; the run needs well under a tenth of this
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	// ****************
	// tasks
	// ****************
	task automatic cmp_code(input string what, input int idx,
			input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s %0d expected %h seen %h", what, idx, exp, got);
		end
	endtask : cmp_code
	task automatic do_reset();
		@(negedge clock_i);
		nrst_i = 1'b0;
		repeat (20) @(negedge clock_i);
		nrst_i = 1'b1;
		i_sink.words.delete();
	endtask : do_reset
	// value held eight cycles either side of the sampling fall
	task automatic period(input logic [sfadc_pkg::ANA_W-1:0] v);
		@(negedge clock_i);
		value = v;
		repeat (8) @(negedge clock_i);
		conv_clk = 1'b0;
		repeat (8) @(negedge clock_i);
		conv_clk = 1'b1;
	endtask : period
	// reset first, so the first strobe belongs to the first sample
	task automatic stream(input logic [sfadc_pkg::ANA_W-1:0] b,
			input logic [sfadc_pkg::ANA_W-1:0] t, input sfadc_vq_t v,
			input sfadc_eq_t e);
		bot_ref = b;
		top_ref = t;
		do_reset();
		foreach (v[i])
			period(v[i]);
		repeat (4)
			period(v[v.size()-1]);
		foreach (e[i])
			cmp_code("word", i, e[i], i_sink.words[i]);
	endtask : stream
	task automatic t_codes();
		stream(12'h100, 12'h900, '{12'h100, 12'h4f8, 12'h500, 12'h108,
			12'h8ff, 12'h900, 12'h050, 12'hfff, 12'h300},
			'{8'h00, 8'h7f, 8'h80, 8'h01, 8'hff, 8'hff, 8'h00, 8'hff,
			8'h40});
	endtask : t_codes
	task automatic t_refs();
		stream(12'h000, 12'h400, '{12'h3fc, 12'h200, 12'h001, 12'h004},
			'{8'hff, 8'h80, 8'h00, 8'h01});
		stream(12'h800, 12'h400, '{12'h600}, '{8'h00});
	endtask : t_refs
	task automatic t_release();
		rel = 1'b1;
		stream(12'h100, 12'h900, '{12'h500, 12'h200}, '{8'hzz, 8'hzz});
		rel = 1'b0;
		// bus must be driven again once the enable drops, no reset between
		repeat (4)
			period(12'h500);
		cmp_code("drive", 0, 8'h80, bus_w);
	endtask : t_release
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// ****************
	// main sequence
	// ****************
	initial begin
		nrst_i = 1'b0;
		conv_clk = 1'b1;
		rel = 1'b0;
		value = 12'h000;
		top_ref = 12'h900;
		bot_ref = 12'h100;
		t_codes();
		t_refs();
		t_release();
		final_report();
	end
endmodule : testbench

`default_nettype wire
